// ---- include/pms_pkg.sv ----
package pms_pkg;
    localparam int PMS_HIST_W = 8;
    localparam logic [7:0] PMS_HIST_RST = 8'h00;
    localparam logic [1:0] PMS_MODE_USER = 2'h1;
    localparam logic [1:0] PMS_MODE_SYS = 2'h0;
    localparam logic [11:0] PMS_SMV_VECTOR = 12'h180;
    localparam logic [1:0] PMS_PRIO_TOP = 2'h3;
    localparam logic [1:0] PMS_PRIO_CAP = 2'h2;
    localparam int PMS_CLK_MHZ = 25;
    localparam int PMS_CYC_ENTER_USER = 4;
    localparam int PMS_CYC_RESTORE = 4;
    localparam int PMS_CYC_PUSH = 9;
    localparam int PMS_CYC_POP = 7;
    localparam int PMS_CYC_READ_MODE = 4;
    localparam int PMS_CYC_DETECT = 2;
    localparam int PMS_CYC_SYSTEM_CALL_OP = 10;
    localparam logic [15:0] PMS_SP_STEP_PUSH = 16'h0001;
    localparam logic [15:0] PMS_SP_STEP_CALL = 16'h0002;
    localparam logic [31:0] PMS_REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] PMS_REG_STATUS = 32'h0000_0004;
    localparam logic [1:0] PMS_RESP_OKAY = 2'h0;
    localparam logic [1:0] PMS_RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        PMS_OP_NONE, PMS_OP_ENTER_USER, PMS_OP_RESTORE, PMS_OP_PUSH, PMS_OP_POP,
        PMS_OP_READ_MODE, PMS_OP_DETECT, PMS_OP_SYSTEM_CALL_OP
    } pms_op_t;
    function automatic logic [7:0] pms_push_mode(input logic [7:0] h, input logic [1:0] m);
        return {h[5:0], m};
    endfunction
endpackage

// ---- src/pms_axil.sv ----
`timescale 1ns/10ps
`default_nettype none
module pms_axil
    import pms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [31:0] status_word,
    output logic dual_mode_enable_flag
);
    logic aw_ff, w_ff, bvalid_ff, rvalid_ff, edm_ff;
    logic [31:0] awaddr_ff, wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    wire do_write = aw_ff && w_ff && !bvalid_ff;
    wire wr_ctrl = awaddr_ff[31:2] == PMS_REG_CTRL[31:2];
    wire wr_stat = awaddr_ff[31:2] == PMS_REG_STATUS[31:2];
    wire rd_ctrl = araddr[31:2] == PMS_REG_CTRL[31:2];
    wire rd_stat = araddr[31:2] == PMS_REG_STATUS[31:2];
    wire rd_take = arvalid && !rvalid_ff;
    wire [31:0] rd_word = rd_ctrl ? {31'h0, edm_ff} : (rd_stat ? status_word : 32'h0);
    assign awready = !aw_ff && !bvalid_ff;
    assign wready = !w_ff && !bvalid_ff;
    assign arready = !rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign dual_mode_enable_flag = edm_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            edm_ff <= 1'b0;
            awaddr_ff <= 32'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bresp_ff <= PMS_RESP_OKAY;
            rresp_ff <= PMS_RESP_OKAY;
            rdata_ff <= 32'h0;
        end else begin
            if (awvalid && awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (do_write) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (wr_ctrl || wr_stat) ? PMS_RESP_OKAY : PMS_RESP_SLVERR;
                if (wr_ctrl && wstrb_ff[0]) begin
                    edm_ff <= wdata_ff[0];
                end
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
            if (rd_take) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_word;
                rresp_ff <= (rd_ctrl || rd_stat) ? PMS_RESP_OKAY : PMS_RESP_SLVERR;
            end else if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/pms_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module pms_timer
    import pms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [3:0] cycles,
    output logic busy,
    output logic last
);
    logic [3:0] cnt_ff;
    wire [3:0] nxt_cnt = start ? cycles : (cnt_ff != 4'h0 ? cnt_ff - 4'h1 : 4'h0);
    assign busy = cnt_ff != 4'h0;
    assign last = cnt_ff == 4'h1;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

// ---- src/pms_top.sv ----
// Behaviour
// - enter-user, interrupt, system_call_op and restart push current mode onto history
// - enter-user, four clocks: history shifts left two, low bits become 01
// - restore, four clocks: history rotates right by two
// - push history, nine clocks: sp minus one, write byte at new sp
// - pop history, seven clocks: read byte at sp, then sp plus one
// - read-mode copies history bit 0 into carry, other flags untouched
// - detect opcode, two clocks, performs plain E self-load whether or not it traps
// - detect in user mode with dual mode on sets violation request
// - alternate-destination prefix makes detect load alternate E, never trap
// - system call, ten clocks: sp minus two, system mode, vector jump
// - interrupts, restarts, system and secure calls enter system mode
// - in user mode with dual mode, protected writes ignored, priority 3 barred
// - violation request clears automatically on acknowledge
// - user-enabled peripheral interrupts requested only at priority 2 or 1
// - priority 3 in user mode with dual mode behaves as priority 2
// - violation uses vector 0x180 and always priority 3
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pms_top
    import pms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [31:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic op_valid,
    input wire pms_op_t op_code,
    input wire logic op_alt_prefix,
    input wire logic entry_event,
    input wire logic secure_call_event,
    input wire logic [15:0] sp_in,
    input wire logic [7:0] mem_rdata,
    input wire logic smv_ack,
    input wire logic prot_wr_req,
    input wire logic [1:0] prio_req,
    input wire logic [1:0] periph_prio_req,
    input wire logic periph_user_en,
    output logic op_busy,
    output logic op_done,
    output logic [15:0] sp_out,
    output logic sp_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    output logic carry_out,
    output logic carry_we,
    output logic load_e_self,
    output logic load_alt_e,
    output logic vector_jump,
    output logic [11:0] vector_offset,
    output logic smv_irq,
    output logic [1:0] smv_prio,
    output logic prot_wr_ok,
    output logic [1:0] prio_eff,
    output logic [1:0] periph_prio_eff,
    output logic [7:0] mode_history,
    output logic user_mode
);
    logic [7:0] hist_ff;
    logic smv_ff, busy_ff, done_ff, sp_we_ff, mem_we_ff, mem_re_ff;
    logic carry_ff, carry_we_ff, ld_e_ff, ld_alt_ff, vjump_ff, prot_ok_ff;
    logic [15:0] sp_ff, maddr_ff;
    logic [7:0] mwdata_ff;
    logic [1:0] prio_ff, pprio_ff;
    pms_op_t cur_ff;
    logic edm_flag, t_busy, t_last;

    wire restricted = edm_flag && hist_ff[0];
    wire start = op_valid && !busy_ff && !t_busy && op_code != PMS_OP_NONE;
    wire [3:0] op_cycles = op_code == PMS_OP_PUSH ? 4'(PMS_CYC_PUSH) :
                           op_code == PMS_OP_POP ? 4'(PMS_CYC_POP) :
                           op_code == PMS_OP_SYSTEM_CALL_OP ? 4'(PMS_CYC_SYSTEM_CALL_OP) :
                           op_code == PMS_OP_DETECT ? 4'(PMS_CYC_DETECT) :
                           op_code == PMS_OP_READ_MODE ? 4'(PMS_CYC_READ_MODE) :
                           op_code == PMS_OP_RESTORE ? 4'(PMS_CYC_RESTORE) : 4'(PMS_CYC_ENTER_USER);
    wire finish = busy_ff && t_last;
    wire entry_now = entry_event || secure_call_event;
    wire system_call_op_fin = finish && cur_ff == PMS_OP_SYSTEM_CALL_OP;
    wire detect_now = start && op_code == PMS_OP_DETECT;
    wire smv_set = detect_now && !op_alt_prefix && restricted;
    wire [31:0] status_word = {19'h0, smv_ff, prio_ff, busy_ff, hist_ff[0], hist_ff};
    logic [7:0] nxt_hist;

    always_comb begin
        nxt_hist = hist_ff;
        if (entry_now || system_call_op_fin) begin
            nxt_hist = pms_push_mode(hist_ff, PMS_MODE_SYS);
        end else if (finish && cur_ff == PMS_OP_ENTER_USER) begin
            nxt_hist = pms_push_mode(hist_ff, PMS_MODE_USER);
        end else if (finish && cur_ff == PMS_OP_RESTORE) begin
            nxt_hist = {hist_ff[1:0], hist_ff[7:2]};
        end else if (finish && cur_ff == PMS_OP_POP) begin
            nxt_hist = mem_rdata;
        end
    end

    pms_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axil_awaddr),
        .awvalid(s_axil_awvalid),
        .awready(s_axil_awready),
        .wdata(s_axil_wdata),
        .wstrb(s_axil_wstrb),
        .wvalid(s_axil_wvalid),
        .wready(s_axil_wready),
        .bresp(s_axil_bresp),
        .bvalid(s_axil_bvalid),
        .bready(s_axil_bready),
        .araddr(s_axil_araddr),
        .arvalid(s_axil_arvalid),
        .arready(s_axil_arready),
        .rdata(s_axil_rdata),
        .rresp(s_axil_rresp),
        .rvalid(s_axil_rvalid),
        .rready(s_axil_rready),
        .status_word(status_word),
        .dual_mode_enable_flag(edm_flag)
    );

    pms_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start),
        .cycles(op_cycles),
        .busy(t_busy),
        .last(t_last)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hist_ff <= PMS_HIST_RST;
            cur_ff <= PMS_OP_NONE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            hist_ff <= nxt_hist;
            done_ff <= finish;
            if (start) begin
                busy_ff <= 1'b1;
                cur_ff <= op_code;
            end else if (finish) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // violation request: set beats acknowledge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smv_ff <= 1'b0;
        end else if (smv_set) begin
            smv_ff <= 1'b1;
        end else if (smv_ack) begin
            smv_ff <= 1'b0;
        end
    end

    // stack and memory side effects, issued on the final cycle except the pop read strobe, issued at start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_ff <= 16'h0;
            sp_we_ff <= 1'b0;
            maddr_ff <= 16'h0;
            mwdata_ff <= 8'h0;
            mem_we_ff <= 1'b0;
            mem_re_ff <= 1'b0;
            vjump_ff <= 1'b0;
        end else begin
            sp_we_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_re_ff <= 1'b0;
            vjump_ff <= 1'b0;
            if (finish && cur_ff == PMS_OP_PUSH) begin
                sp_ff <= sp_in - PMS_SP_STEP_PUSH;
                maddr_ff <= sp_in - PMS_SP_STEP_PUSH;
                mwdata_ff <= hist_ff;
                mem_we_ff <= 1'b1;
                sp_we_ff <= 1'b1;
            end else if (finish && cur_ff == PMS_OP_POP) begin
                sp_ff <= sp_in + PMS_SP_STEP_PUSH;
                sp_we_ff <= 1'b1;
            end else if (system_call_op_fin) begin
                sp_ff <= sp_in - PMS_SP_STEP_CALL;
                sp_we_ff <= 1'b1;
                vjump_ff <= 1'b1;
            end
            if (start && op_code == PMS_OP_POP) begin
                maddr_ff <= sp_in;
                mem_re_ff <= 1'b1;
            end
        end
    end

    // flags, loads and priority limits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry_ff <= 1'b0;
            carry_we_ff <= 1'b0;
            ld_e_ff <= 1'b0;
            ld_alt_ff <= 1'b0;
            prot_ok_ff <= 1'b0;
            prio_ff <= 2'h0;
            pprio_ff <= 2'h0;
        end else begin
            carry_we_ff <= finish && cur_ff == PMS_OP_READ_MODE;
            carry_ff <= hist_ff[0];
            ld_e_ff <= detect_now && !op_alt_prefix;
            ld_alt_ff <= detect_now && op_alt_prefix;
            prot_ok_ff <= prot_wr_req && !restricted;
            prio_ff <= (restricted && prio_req == PMS_PRIO_TOP) ? PMS_PRIO_CAP : prio_req;
            pprio_ff <= (periph_user_en && periph_prio_req == PMS_PRIO_TOP) ? PMS_PRIO_CAP
                                                                             : periph_prio_req;
        end
    end

    assign op_busy = busy_ff;
    assign op_done = done_ff;
    assign sp_out = sp_ff;
    assign sp_we = sp_we_ff;
    assign mem_addr = maddr_ff;
    assign mem_wdata = mwdata_ff;
    assign mem_we = mem_we_ff;
    assign mem_re = mem_re_ff;
    assign carry_out = carry_ff;
    assign carry_we = carry_we_ff;
    assign load_e_self = ld_e_ff;
    assign load_alt_e = ld_alt_ff;
    assign vector_jump = vjump_ff;
    assign vector_offset = PMS_SMV_VECTOR;
    assign smv_irq = smv_ff;
    assign smv_prio = PMS_PRIO_TOP;
    assign prot_wr_ok = prot_ok_ff;
    assign prio_eff = prio_ff;
    assign periph_prio_eff = pprio_ff;
    assign mode_history = hist_ff;
    assign user_mode = hist_ff[0];
endmodule
`default_nettype wire

// ---- tb/pms_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module pms_chk
    import pms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic op_valid,
    input wire pms_op_t op_code,
    input wire logic op_alt_prefix,
    input wire logic op_busy,
    input wire logic op_done,
    input wire logic entry_event,
    input wire logic smv_ack,
    input wire logic periph_user_en,
    input wire logic sp_we,
    input wire logic [15:0] sp_out,
    input wire logic [15:0] mem_addr,
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic carry_out,
    input wire logic carry_we,
    input wire logic load_e_self,
    input wire logic load_alt_e,
    input wire logic [11:0] vector_offset,
    input wire logic smv_irq,
    input wire logic [1:0] smv_prio,
    input wire logic [1:0] periph_prio_eff,
    input wire logic [7:0] mode_history
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic go;
    assign go = op_valid && !op_busy;
    chk_vec_fixed: assert property (vector_offset == PMS_SMV_VECTOR && smv_prio == PMS_PRIO_TOP)
        else $error("violation vector or priority wrong");
    chk_enter_shift: assert property (go && op_code == PMS_OP_ENTER_USER |->
        ##6 mode_history == {$past(mode_history[5:0], 6), PMS_MODE_USER})
        else $error("enter user history wrong");
    chk_restore_rot: assert property (go && op_code == PMS_OP_RESTORE |->
        ##6 mode_history == {$past(mode_history[1:0], 6), $past(mode_history[7:2], 6)})
        else $error("restore rotation wrong");
    chk_entry_push: assert property (entry_event |->
        ##2 mode_history == {$past(mode_history[5:0], 2), PMS_MODE_SYS})
        else $error("entry push wrong");
    chk_push_addr: assert property (mem_we |-> sp_we && mem_addr == sp_out)
        else $error("push address not new sp");
    chk_read_carry: assert property (carry_we |-> carry_out == mode_history[0])
        else $error("carry not history bit 0");
    chk_detect_time: assert property (go && op_code == PMS_OP_DETECT |-> ##3 op_done)
        else $error("detect length wrong");
    chk_alt_load: assert property (go && op_code == PMS_OP_DETECT && op_alt_prefix |->
        ##1 load_alt_e && !load_e_self)
        else $error("alternate load missing");
    chk_self_load: assert property (go && op_code == PMS_OP_DETECT && !op_alt_prefix |->
        ##1 load_e_self && !load_alt_e)
        else $error("plain self load missing");
    chk_pop_read: assert property (go && op_code == PMS_OP_POP |-> ##1 mem_re)
        else $error("pop read strobe missing");
    chk_push_span: assert property (go && op_code == PMS_OP_PUSH |->
        ##1 op_busy [*8] ##1 op_busy ##1 !op_busy && op_done)
        else $error("push length wrong");
    chk_smv_clear: assert property ($fell(smv_irq) |-> $past(smv_ack))
        else $error("violation cleared without ack");
    chk_periph_cap: assert property ($past(periph_user_en) |-> periph_prio_eff != PMS_PRIO_TOP)
        else $error("user peripheral at priority 3");
endmodule
bind pms_top pms_chk u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .op_valid(op_valid),
    .op_code(op_code),
    .op_alt_prefix(op_alt_prefix),
    .op_busy(op_busy),
    .op_done(op_done),
    .entry_event(entry_event),
    .smv_ack(smv_ack),
    .periph_user_en(periph_user_en),
    .sp_we(sp_we),
    .sp_out(sp_out),
    .mem_addr(mem_addr),
    .mem_we(mem_we),
    .mem_re(mem_re),
    .carry_out(carry_out),
    .carry_we(carry_we),
    .load_e_self(load_e_self),
    .load_alt_e(load_alt_e),
    .vector_offset(vector_offset),
    .smv_irq(smv_irq),
    .smv_prio(smv_prio),
    .periph_prio_eff(periph_prio_eff),
    .mode_history(mode_history)
);
`default_nettype wire

// ---- tb/pms_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pms_core_model (
    input wire logic aclk,
    input wire logic [15:0] sp_init,
    input wire logic sp_load,
    input wire logic [15:0] sp_out,
    input wire logic sp_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    output logic [15:0] sp_in,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem_ff [256];
    // stack pointer datapath and byte memory of the core
    always_ff @(posedge aclk) begin
        if (sp_load) sp_in <= sp_init;
        else if (sp_we) sp_in <= sp_out;
        if (mem_we) mem_ff[mem_addr[7:0]] <= mem_wdata;
    end
    assign mem_rdata = mem_ff[sp_in[7:0]];
endmodule
`default_nettype wire

// ---- tb/tb_privilege_mode_stack.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_privilege_mode_stack
    import pms_pkg::*;
;
    logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
    logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready, op_valid;
    logic op_alt_prefix, entry_event, secure_call_event, smv_ack, prot_wr_req, periph_user_en, op_busy;
    logic op_done, sp_we, mem_we, mem_re, carry_out, carry_we, load_e_self, load_alt_e, vector_jump;
    logic smv_irq, prot_wr_ok, user_mode;
    logic [31:0] s_axil_awaddr, s_axil_wdata, s_axil_araddr, s_axil_rdata, rd;
    logic [3:0] s_axil_wstrb;
    logic [1:0] s_axil_bresp, s_axil_rresp, prio_req, periph_prio_req, smv_prio, prio_eff, periph_prio_eff, rs;
    logic [15:0] sp_in, sp_out, mem_addr;
    logic [7:0] mem_rdata, mem_wdata, mode_history;
    logic [11:0] vector_offset;
    pms_op_t op_code;
    int n_mismatch, checks_done;
    pms_top DUT (.*);
    pms_core_model u_core (.aclk, .sp_init(16'h0080), .sp_load(!aresetn), .sp_out, .sp_we, .mem_addr, .mem_wdata,
        .mem_we, .sp_in, .mem_rdata);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
        end while (!s_axil_bvalid);
        rs = s_axil_bresp;
        s_axil_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axr(input logic [31:0] a);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
        end while (!s_axil_rvalid);
        rd = s_axil_rdata;
        rs = s_axil_rresp;
        s_axil_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic run_op(input pms_op_t c, input logic alt);
        op_code <= c;
        op_alt_prefix <= alt;
        op_valid <= 1'b1;
        @(posedge aclk);
        op_valid <= 1'b0;
        do @(posedge aclk); while (!op_done);
    endtask
    task automatic t_reset();
        axr(PMS_REG_STATUS);
        chk(rd, 32'h0000_0000);
        axr(PMS_REG_CTRL);
        chk(rd, 32'h0000_0000);
        axr(32'h0000_0010);
        chk(rs, PMS_RESP_SLVERR);
        prot_wr_req <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(prot_wr_ok, 1'b1);
        prot_wr_req <= 1'b0;
        run_op(PMS_OP_DETECT, 1'b0);
        chk(smv_irq, 1'b0);
        $display("reset test end");
    endtask
    task automatic t_user();
        periph_user_en <= 1'b1;
        axw(PMS_REG_CTRL, 32'h0000_0001);
        chk(rs, PMS_RESP_OKAY);
        run_op(PMS_OP_ENTER_USER, 1'b0);
        chk(mode_history, 8'h01);
        run_op(PMS_OP_READ_MODE, 1'b0);
        chk(carry_we, 1'b1);
        chk(carry_out, 1'b1);
        axr(PMS_REG_STATUS);
        chk(rd, 32'h0000_0101);
        $display("user entry test end");
    endtask
    task automatic t_detect();
        run_op(PMS_OP_DETECT, 1'b1);
        chk(smv_irq, 1'b0);
        run_op(PMS_OP_DETECT, 1'b0);
        chk(smv_irq, 1'b1);
        smv_ack <= 1'b1;
        @(posedge aclk);
        smv_ack <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(smv_irq, 1'b0);
        $display("detect test end");
    endtask
    task automatic t_limits();
        prio_req <= 2'h3;
        periph_prio_req <= 2'h3;
        prot_wr_req <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(prio_eff, PMS_PRIO_CAP);
        chk(periph_prio_eff, PMS_PRIO_CAP);
        chk(prot_wr_ok, 1'b0);
        prot_wr_req <= 1'b0;
        $display("limits test end");
    endtask
    task automatic t_stack();
        run_op(PMS_OP_PUSH, 1'b0);
        @(posedge aclk);
        chk(sp_in, 16'h007F);
        chk(u_core.mem_ff[8'h7F], 8'h01);
        run_op(PMS_OP_ENTER_USER, 1'b0);
        chk(mode_history, 8'h05);
        run_op(PMS_OP_POP, 1'b0);
        chk(mode_history, 8'h01);
        chk(sp_out, 16'h0080);
        run_op(PMS_OP_SYSTEM_CALL_OP, 1'b0);
        chk(sp_out, 16'h007E);
        chk(vector_jump, 1'b1);
        chk(mode_history, 8'h04);
        run_op(PMS_OP_RESTORE, 1'b0);
        chk(mode_history, 8'h01);
        $display("stack test end");
    endtask
    task automatic t_entry();
        entry_event <= 1'b1;
        @(posedge aclk);
        entry_event <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(mode_history, 8'h04);
        chk(prio_eff, PMS_PRIO_TOP);
        run_op(PMS_OP_RESTORE, 1'b0);
        secure_call_event <= 1'b1;
        @(posedge aclk);
        secure_call_event <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(user_mode, 1'b0);
        $display("entry test end");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready, op_valid,
            op_alt_prefix, entry_event, secure_call_event, smv_ack, prot_wr_req, periph_user_en, prio_req,
            periph_prio_req, s_axil_awaddr, s_axil_wdata, s_axil_araddr} = '0;
        s_axil_wstrb = 4'hF;
        op_code = PMS_OP_NONE;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_user();
        t_detect();
        t_limits();
        t_stack();
        t_entry();
        end_of_test();
    end
endmodule
`default_nettype wire
